/* File: hdl/fault_sequencer.sv */
// Purpose: Fault classes, brownout and line-removal timers of a flyback controller.
// Assumes: Comparator flags arrive from the analog side, asynchronous to the clock.
// Notes:   Long timers count a 1 us tick; their lengths are parameters.
// Functional notes
// - Three fault classes: latching, non-latching restart, auto-recovery after timer.
// - Abnormal overcurrent, supply overvoltage and external latch request are latching.
// - A latching fault drops gate enable at once.
// - Latched: keep cycling supply, never restart at start level.
// - Latch clears only on supply below clear level or line removal.
// - Brownout and thermal shutdown are non-latching; gate drive off.
// - Non-latching: source on at stop level, off at start level, repeat.
// - After non-latching fault clears, restart at start level if line ok.
// - Supply already above start level at clear: restart at once if line ok.
// - Auto-recovery fault drops gate and starts 1.2 s timer.
// - During recovery timer, source toggles between stop and start levels.
// - After recovery timer, start at next start level if line ok.
// - Line below low level for 54 ms declares brownout.
// - Brownout stops switching until line returns above ok level.
// - Line slope detection runs in every state.
// - Line-loss timer of 100 ms runs while slope is too small.
// - Rise seen clear 14 ms or fall seen clear 1 ms resets line-loss timer.
// - Line-loss expiry declares removal, starts discharge, disables controller.
// - Discharge ending at end level begins a normal startup.
// - External fault requests are accepted after 30 us persistence.
module fault_sequencer #(
   parameter int unsigned RECOVERY_WAIT = fault_seq_pkg::RECOVERY_WAIT_TK,
   parameter int unsigned LINE_LOW_WAIT = fault_seq_pkg::LINE_LOW_WAIT_TK,
   parameter int unsigned LINE_LOSS     = fault_seq_pkg::LINE_LOSS_WAIT_TK,
   parameter int unsigned RISE_CLEAR    = fault_seq_pkg::RISE_CLEAR_TK,
   parameter int unsigned FALL_CLEAR    = fault_seq_pkg::FALL_CLEAR_TK,
   parameter int unsigned TICK          = fault_seq_pkg::TICK_CYC
) (
   input  wire logic clk_sys_in,
   input  wire logic rstn_in,
   input  wire logic supply_start_in,
   input  wire logic supply_stop_in,
   input  wire logic supply_clear_in,
   input  wire logic supply_ovp_in,
   input  wire logic abnormal_overcurrent_in,
   input  wire logic thermal_shutdown_in,
   input  wire logic ext_latch_req_in,
   input  wire logic ext_temp_fault_in,
   input  wire logic recovery_fault_in,
   input  wire logic line_ok_level_in,
   input  wire logic line_low_level_in,
   input  wire logic rise_seen_in,
   input  wire logic fall_seen_in,
   input  wire logic disch_end_in,
   output logic      gate_en_out,
   output logic      startup_src_en_out,
   output logic      discharge_req_out,
   output fault_seq_pkg::seq_state_t state_out
);
   import fault_seq_pkg::*;

   initial begin
      if (TICK < 1 || LINE_LOSS < 2 || RECOVERY_WAIT < 1 || LINE_LOW_WAIT < 1 ||
          RISE_CLEAR < 1 || FALL_CLEAR < 1 || RECOVERY_WAIT >= (1 << TIMER_W) ||
          LINE_LOW_WAIT >= (1 << TIMER_W) || LINE_LOSS >= (1 << TIMER_W) ||
          RISE_CLEAR >= (1 << TIMER_W) || FALL_CLEAR >= (1 << TIMER_W) || TICK > 65536)
         $error("fault_sequencer: timer parameters out of range.");
   end

   // Synchronised comparator flags.
   logic s_start, s_stop, s_clear, s_ovp, s_abnormal_overcurrent, s_tsd, s_ext_latch, s_ext_temp;
   logic s_recov, s_line_ok, s_line_low, s_rise, s_fall, s_disch_end;
   wire [13:0] raw_flags = {supply_start_in, supply_stop_in, supply_clear_in,
                            supply_ovp_in, abnormal_overcurrent_in, thermal_shutdown_in,
                            recovery_fault_in, line_ok_level_in, line_low_level_in,
                            rise_seen_in, fall_seen_in, disch_end_in,
                            ext_latch_req_in, ext_temp_fault_in};
   wire [13:0] s_flags;
   assign {s_start, s_stop, s_clear, s_ovp, s_abnormal_overcurrent, s_tsd, s_recov, s_line_ok,
           s_line_low, s_rise, s_fall, s_disch_end, s_ext_latch, s_ext_temp} = s_flags;

   genvar gi;
   generate
      for (gi = 0; gi < 14; gi++) begin : g_sync
         localparam int unsigned BL = (gi < 2) ? BLANK_CYC : 1;
         pin_filter #(.BLANK(BL)) u_filt (
            .clk_sys_in (clk_sys_in),
            .rstn_in    (rstn_in),
            .raw_in     (raw_flags[gi]),
            .level_out  (s_flags[gi])
         );
      end
   endgenerate

   // Slow tick divider.
   logic [15:0] tick_cnt_q;
   wire         tick = (tick_cnt_q == 16'(TICK - 1));
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) tick_cnt_q <= 16'h0000;
      else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
   end

   // Fault classification.
   logic brownout_q;
   wire latch_fault = s_abnormal_overcurrent | s_ovp | s_ext_latch;
   wire nl_fault    = s_tsd | s_ext_temp | brownout_q;

   // Brownout timer: counts while line below low level.
   logic [TIMER_W-1:0] bo_cnt_q;
   wire bo_expire = tick && (bo_cnt_q == TIMER_W'(LINE_LOW_WAIT - 1));
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bo_cnt_q   <= '0;
         brownout_q <= 1'b0;
      end else begin
         if (!s_line_low) bo_cnt_q <= '0;
         else if (tick && !bo_expire && !brownout_q) bo_cnt_q <= bo_cnt_q + TIMER_W'(1);
         if (bo_expire) brownout_q <= 1'b1;
         else if (s_line_ok) brownout_q <= 1'b0;
      end
   end

   // Line-loss detection runs in every state.
   logic [TIMER_W-1:0] up_cnt_q, dn_cnt_q, loss_cnt_q;
   wire up_active   = (up_cnt_q != '0);
   wire dn_active   = (dn_cnt_q != '0);
   wire slope_low   = !up_active && !dn_active;
   wire loss_expire = tick && slope_low && (loss_cnt_q == TIMER_W'(LINE_LOSS - 1));
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         up_cnt_q   <= '0;
         dn_cnt_q   <= '0;
         loss_cnt_q <= '0;
      end else begin
         if (s_rise) up_cnt_q <= TIMER_W'(RISE_CLEAR);
         else if (tick && up_active) up_cnt_q <= up_cnt_q - TIMER_W'(1);
         if (s_fall) dn_cnt_q <= TIMER_W'(FALL_CLEAR);
         else if (tick && dn_active) dn_cnt_q <= dn_cnt_q - TIMER_W'(1);
         if (!slope_low || s_rise || s_fall || loss_expire) loss_cnt_q <= '0;
         else if (tick) loss_cnt_q <= loss_cnt_q + TIMER_W'(1);
      end
   end

   // Sequencer.
   seq_state_t state_q, state_d;
   logic [TIMER_W-1:0] rec_cnt_q;
   logic rec_done_q, src_q, src_d;
   wire rec_expire = tick && (rec_cnt_q == TIMER_W'(RECOVERY_WAIT - 1));
   wire nl_clear   = !nl_fault && s_line_ok;

   always_comb begin
      state_d = state_q;
      src_d   = src_q;
      // Supply hysteresis: on at stop level, off at start level.
      if (s_stop) src_d = 1'b1;
      else if (s_start) src_d = 1'b0;
      case (state_q)
         ST_START: begin
            src_d = !s_start;
            if (s_start && s_line_ok) state_d = ST_RUN;
         end
         ST_RUN: begin
            src_d = 1'b0;
            if (nl_fault) state_d = ST_NLATCH;
            else if (s_recov) state_d = ST_AUTOR;
         end
         ST_NLATCH: begin
            if (nl_clear && s_start) state_d = ST_RUN;
         end
         ST_AUTOR: begin
            if (rec_done_q && s_start && s_line_ok && !nl_fault) state_d = ST_RUN;
         end
         ST_LATCH: begin
            if (s_clear) begin
               state_d = ST_START;
               src_d   = 1'b1;
            end
         end
         ST_DISCH: begin
            src_d = 1'b0;
            if (s_disch_end) state_d = ST_START;
         end
         default: state_d = ST_START;
      endcase
      // Latching faults win over all states except discharge, only removal beats them.
      if (loss_expire) state_d = ST_DISCH;
      else if (latch_fault && state_q != ST_DISCH) state_d = ST_LATCH;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= ST_START;
         src_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         src_q   <= src_d;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rec_cnt_q  <= '0;
         rec_done_q <= 1'b0;
      end else if (state_q != ST_AUTOR) begin
         rec_cnt_q  <= '0;
         rec_done_q <= 1'b0;
      end else if (tick && !rec_done_q) begin
         rec_cnt_q  <= rec_cnt_q + TIMER_W'(1);
         rec_done_q <= rec_expire;
      end
   end

   // Gate enable drops in the same cycle the latching fault is seen.
   assign gate_en_out        = (state_q == ST_RUN) && !latch_fault && !loss_expire;
   assign startup_src_en_out = src_q;
   assign discharge_req_out  = (state_q == ST_DISCH);
   assign state_out          = state_q;

   // Checks.
   sequence s_latch_seen;
      latch_fault && state_q != ST_DISCH && !loss_expire;
   endsequence

   chk_latch_gate_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      latch_fault |-> !gate_en_out) else $error("Gate on during latching fault.");
   chk_latch_entry: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_latch_seen |=> state_q == ST_LATCH) else $error("Latch not entered.");
   chk_latch_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      state_q == ST_LATCH && !s_clear && !loss_expire |=> state_q == ST_LATCH)
      else $error("Latch left without clear.");
   chk_latch_no_run: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      state_q == ST_LATCH |=> state_q != ST_RUN) else $error("Restart from latch.");
   chk_nl_gate_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      state_q == ST_RUN && nl_fault && !latch_fault && !loss_expire
      |=> state_q == ST_NLATCH ##0 !gate_en_out) else $error("Non-latching fault missed.");
   chk_src_hyst: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      state_q == ST_NLATCH && state_d == ST_NLATCH && s_stop |=> src_q)
      else $error("Source not on at stop level.");
   chk_run_needs_line: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      $rose(state_q == ST_RUN) |-> $past(s_line_ok)) else $error("Start without line ok.");
   chk_autor_wait: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      state_q == ST_AUTOR && !rec_done_q |=> state_q != ST_RUN)
      else $error("Recovery left early.");
   chk_disch_req: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      loss_expire |=> discharge_req_out && !gate_en_out) else $error("No discharge.");
   chk_bo_declare: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      bo_expire |=> brownout_q) else $error("Brownout not declared.");
   chk_loss_reset: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_rise || s_fall |=> loss_cnt_q == '0) else $error("Line-loss timer not reset.");
endmodule : fault_sequencer

/* File: inc/fault_seq_pkg.sv */
// Purpose: Shared constants and types for the flyback fault sequencer.
// Assumes: System clock of 250 MHz; long counts use a slow tick of 1 us.
// Notes:   Times are kept in their printed unit; cycle counts derive from them.
package fault_seq_pkg;
   localparam int unsigned CLK_HZ            = 250_000_000;
   localparam int unsigned TICK_US           = 1;
   localparam int unsigned TICK_CYC          = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned BLANK_US          = 30;
   localparam int unsigned BLANK_CYC         = BLANK_US * (CLK_HZ / 1_000_000) + 1;
   localparam int unsigned RECOVERY_WAIT_MS  = 1200;
   localparam int unsigned LINE_LOW_WAIT_MS  = 54;
   localparam int unsigned LINE_LOSS_WAIT_MS = 100;
   localparam int unsigned RISE_CLEAR_MS     = 14;
   localparam int unsigned FALL_CLEAR_MS     = 1;
   localparam int unsigned RECOVERY_WAIT_TK  = RECOVERY_WAIT_MS * 1000 / TICK_US;
   localparam int unsigned LINE_LOW_WAIT_TK  = LINE_LOW_WAIT_MS * 1000 / TICK_US;
   localparam int unsigned LINE_LOSS_WAIT_TK = LINE_LOSS_WAIT_MS * 1000 / TICK_US;
   localparam int unsigned RISE_CLEAR_TK     = RISE_CLEAR_MS * 1000 / TICK_US;
   localparam int unsigned FALL_CLEAR_TK     = FALL_CLEAR_MS * 1000 / TICK_US;
   localparam int unsigned TIMER_W           = 21;

   typedef enum logic [5:0] {
      ST_START  = 6'h01,
      ST_RUN    = 6'h02,
      ST_NLATCH = 6'h04,
      ST_AUTOR  = 6'h08,
      ST_LATCH  = 6'h10,
      ST_DISCH  = 6'h20
   } seq_state_t;
endpackage : fault_seq_pkg

/* File: hdl/pin_filter.sv */
// Purpose: Three-stage synchroniser with optional persistence blanking.
// Assumes: Input is asynchronous to clk_sys_in.
// Notes:   Output changes only after the input holds for BLANK cycles.
module pin_filter #(
   parameter int unsigned BLANK = 1
) (
   input  wire logic clk_sys_in,
   input  wire logic rstn_in,
   input  wire logic raw_in,
   output logic      level_out
);
   import fault_seq_pkg::*;

   initial begin
      if (BLANK < 1 || BLANK > 65535) $error("pin_filter: BLANK out of range.");
   end

   logic [2:0]  sync_q;
   logic [15:0] cnt_q;
   wire         stable = (sync_q[2] == sync_q[1]);
   wire         differs = (sync_q[2] != level_out);

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_q    <= 3'h0;
         cnt_q     <= 16'h0000;
         level_out <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], raw_in};
         if (!stable || !differs) begin
            cnt_q <= 16'h0000;
         end else if (cnt_q >= 16'(BLANK - 1)) begin
            cnt_q     <= 16'h0000;
            level_out <= sync_q[2];
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule : pin_filter

/* File: dv/supply_model.sv */
// Purpose: Behavioural supply capacitor with start, stop and clear comparators.
// Assumes: Aux winding holds the supply while the gate runs.
// Notes:   Level 0..40; stop at 10 or less, start at 30 or more, clear below 3.
module supply_model (
   input  wire logic clk_sys_in,
   input  wire logic rstn_in,
   input  wire logic src_en_in,
   input  wire logic gate_en_in,
   input  wire logic drain_in,
   output logic      start_out,
   output logic      stop_out,
   output logic      clear_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int   vcc;
   logic slow;
   // Level moves one step every second clock; drain models a forced discharge.
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vcc  <= 0;
         slow <= 1'b0;
      end else begin
         slow <= ~slow;
         if (slow) begin
            if (drain_in && vcc > 0) vcc <= vcc - 1;
            else if (!drain_in && src_en_in && vcc < 40) vcc <= vcc + 1;
            else if (!drain_in && !src_en_in && !gate_en_in && vcc > 0) vcc <= vcc - 1;
         end
      end
   end
   assign start_out = (vcc >= 30);
   assign stop_out  = (vcc <= 10);
   assign clear_out = (vcc < 3);
endmodule : supply_model

/* File: dv/fault_sequencer_tb.sv */
// Purpose: Self-checking bench for the fault sequencer.
// Assumes: Short timer parameters except FALL_CLEAR (left at 1000 ticks), with a two-cycle tick.
// Notes:   Slope input held high keeps line loss away except where tested.
module fault_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fault_seq_pkg::*;
   typedef struct packed {logic [5:0] flt; seq_state_t exp;} row_t;
   logic clk_sys_in, rstn_in, st, sp, cl, drain, ovp, abnormal_overcurrent, xlat, thermal, xtemp, recf;
   logic line_ok, line_low, rise, fall, dend, gate, src, disch, src_prev;
   seq_state_t state;
   int   err_count, total_checks, rises;
   row_t rows [6] = '{'{6'h20, ST_LATCH}, '{6'h10, ST_LATCH}, '{6'h08, ST_LATCH},
                      '{6'h04, ST_NLATCH}, '{6'h02, ST_NLATCH}, '{6'h01, ST_AUTOR}};
   fault_sequencer #(.RECOVERY_WAIT(6), .LINE_LOW_WAIT(6), .LINE_LOSS(20), .RISE_CLEAR(6),
      .TICK(2)) dut (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .supply_start_in(st),
      .supply_stop_in(sp), .supply_clear_in(cl), .supply_ovp_in(ovp),
      .abnormal_overcurrent_in(abnormal_overcurrent), .thermal_shutdown_in(thermal),
      .ext_latch_req_in(xlat), .ext_temp_fault_in(xtemp), .recovery_fault_in(recf),
      .line_ok_level_in(line_ok), .line_low_level_in(line_low), .rise_seen_in(rise),
      .fall_seen_in(fall), .disch_end_in(dend), .gate_en_out(gate),
      .startup_src_en_out(src), .discharge_req_out(disch), .state_out(state));
   supply_model vcc_model (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .src_en_in(src),
      .gate_en_in(gate), .drain_in(drain), .start_out(st), .stop_out(sp), .clear_out(cl));
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : step
   task automatic summarize();
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic chk_state(input logic [5:0] got, input logic [5:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_state
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wait_state(input seq_state_t s, input int n);
      for (int i = 0; i < n && state !== s; i++) step(1);
      chk_state(state, s);
      if (state !== s) summarize();
   endtask : wait_state
   task automatic set_flt(input logic [5:0] f);
      {ovp, abnormal_overcurrent, xlat, thermal, xtemp, recf} = f;
   endtask : set_flt
   task automatic bring_up();
      rstn_in = 1'b0;
      step(8);
      chk_bit(gate, 1'b0);
      chk_bit(src, 1'b1);
      chk_bit(disch, 1'b0);
      chk_state(state, ST_START);
      rstn_in = 1'b1;
      wait_state(ST_RUN, 400);
      chk_bit(gate, 1'b1);
   endtask : bring_up
   initial begin
      err_count = 0;
      total_checks = 0;
      rstn_in = 1'b0;
      drain = 1'b0;
      set_flt(6'h00);
      line_ok = 1'b1;
      line_low = 1'b0;
      rise = 1'b1;
      fall = 1'b0;
      dend = 1'b0;
      step(1);
      foreach (rows[i]) begin
         bring_up();
         set_flt(rows[i].flt);
         wait_state(rows[i].exp, 8000);
         chk_bit(gate, 1'b0);
         set_flt(6'h00);
      end
      bring_up();
      ovp = 1'b1;
      step(5);
      chk_bit(gate, 1'b0);
      ovp = 1'b0;
      thermal = 1'b1;
      step(20);
      chk_state(state, ST_LATCH);
      thermal = 1'b0;
      rises = 0;
      src_prev = src;
      for (int i = 0; i < 300; i++) begin
         step(1);
         if (src && !src_prev) rises++;
         src_prev = src;
         if (state !== ST_LATCH) rises = -1000;
      end
      chk_bit(rises > 0, 1'b1);
      drain = 1'b1;
      step(80);
      drain = 1'b0;
      wait_state(ST_RUN, 600);
      xlat = 1'b1;
      step(100);
      xlat = 1'b0;
      step(20);
      chk_state(state, ST_RUN);
      thermal = 1'b1;
      wait_state(ST_NLATCH, 20);
      thermal = 1'b0;
      wait_state(ST_RUN, 600);
      recf = 1'b1;
      wait_state(ST_AUTOR, 20);
      recf = 1'b0;
      wait_state(ST_RUN, 600);
      line_ok = 1'b0;
      line_low = 1'b1;
      step(6);
      chk_state(state, ST_RUN);
      wait_state(ST_NLATCH, 40);
      line_low = 1'b0;
      step(100);
      chk_state(state, ST_NLATCH);
      line_ok = 1'b1;
      wait_state(ST_RUN, 600);
      rise = 1'b0;
      fall = 1'b1;
      step(150);
      chk_state(state, ST_RUN);
      fall = 1'b0;
      ovp = 1'b1;
      wait_state(ST_LATCH, 20);
      ovp = 1'b0;
      wait_state(ST_DISCH, 2300);
      chk_bit(disch, 1'b1);
      chk_bit(gate, 1'b0);
      rise = 1'b1;
      dend = 1'b1;
      step(8);
      dend = 1'b0;
      wait_state(ST_RUN, 600);
      chk_bit(disch, 1'b0);
      summarize();
   end
endmodule : fault_sequencer_tb
